// File: hw/asfe_cfg.svh
`ifndef ASFE_CFG_SVH
`define ASFE_CFG_SVH
`define ASFE_I2C_ADDR   7'h3a
`define ASFE_REG_POWER  8'h01
`define ASFE_REG_PATH   8'h02
`define ASFE_REG_FORMAT 8'h03
`define ASFE_REG_VOLUME 8'h04
`define ASFE_REG_RAMP   8'h05
`define ASFE_REG_STATUS 8'h06
`define ASFE_REG_APPLY  8'h07
`define ASFE_POWER_RST  8'h01
`define ASFE_PATH_RST   8'h01
`define ASFE_FORMAT_RST 8'h0c
`define ASFE_VOLUME_RST 8'hcf
`define ASFE_RAMP_RST   8'h00
`define ASFE_BIT_SD     0
`define ASFE_BIT_HPF    7
`define ASFE_BIT_RAMP   7
`define ASFE_BIT_SPEED  4
`define ASFE_FMT_LO     0
`define ASFE_LEN_LO     2
`define ASFE_BOOST_LO   0
`define ASFE_BOOST_HW   2'd1
`define ASFE_LEN_24     2'd3
`define ASFE_VOL_UNITY  8'hcf
`define ASFE_VOL_MUTE   8'h00
`define ASFE_VOL_OFFS   9'd9
`define ASFE_VOL_DIV    9'd12
`define ASFE_VOL_SHIFT  6'd37
`define ASFE_HPF_SHIFT  10
`define ASFE_RAMP_LAST  3'd7
`define ASFE_CNT_MAX    6'd63
`endif

// File: hw/asfe_pkg.sv
`include "asfe_cfg.svh"
package asfe_pkg;
   typedef logic signed [23:0] asfe_smp_t;
   typedef enum logic [1:0] {
      ASFE_FMT_I2S, ASFE_FMT_LJ, ASFE_FMT_RJ, ASFE_FMT_RSV
   } asfe_fmt_e;
   typedef enum logic [2:0] {
      I2C_IDLE, I2C_ADDR, I2C_ACK_A, I2C_PTR, I2C_ACK_W, I2C_WDATA,
      I2C_RDATA, I2C_RACK
   } asfe_i2c_st_e;
   // word length code to bit count: 16, 18, 20, 24
   function automatic logic [4:0] asfe_len_bits(input logic [1:0] code);
      case (code)
         2'd0:    return 5'd16;
         2'd1:    return 5'd18;
         2'd2:    return 5'd20;
         default: return 5'd24;
      endcase
   endfunction : asfe_len_bits
endpackage : asfe_pkg

// File: hw/asfe_rx.sv
`timescale 1ns/100ps
module asfe_rx (
   input  wire logic              bit_clock,
   input  wire logic              reset_n,
   input  wire logic              channel_select_clock,
   input  wire logic              serial_data,
   input  wire logic [1:0]        fmt_cfg,
   input  wire logic [1:0]        len_cfg,
   output asfe_pkg::asfe_smp_t    word,
   output logic                   word_left,
   output logic                   word_tgl
);
   import asfe_pkg::*;
   logic [1:0]  fmt_s1, fmt_s2, len_s1, len_s2;
   logic        lr_q;
   logic [5:0]  cnt;
   logic [23:0] acc, sr, next_acc, next_sr, mask;
   logic        edge_seen, is_i2s, hit;
   logic [5:0]  pos, k;
   logic [4:0]  lim;

   // config comes from the system clock domain
   always_ff @(posedge bit_clock or negedge reset_n) begin
      if (!reset_n) begin
         fmt_s1 <= 2'h0;
         fmt_s2 <= 2'h0;
         len_s1 <= 2'h3;
         len_s2 <= 2'h3;
      end else begin
         fmt_s1 <= fmt_cfg;
         fmt_s2 <= fmt_s1;
         len_s1 <= len_cfg;
         len_s2 <= len_s1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      is_i2s    = fmt_s2 != ASFE_FMT_LJ && fmt_s2 != ASFE_FMT_RJ;
      edge_seen = channel_select_clock != lr_q;
      pos       = edge_seen ? 6'h00 : cnt;
      k         = pos - (is_i2s ? 6'h01 : 6'h00);
      lim       = is_i2s ? 5'd24 : asfe_len_bits(len_s2);
      hit       = fmt_s2 != ASFE_FMT_RJ && !(is_i2s && pos == 6'h00)
                  && k < {1'b0, lim};
      next_acc  = edge_seen ? 24'h0 : acc;
      if (hit)
         next_acc[5'(6'd23 - k)] = serial_data;
      next_sr   = {sr[22:0], serial_data};
      mask      = 24'((25'h1 << asfe_len_bits(len_s2)) - 25'h1);
   end

   // bits taken on rising bit clock, word handed on at edge
   always_ff @(posedge bit_clock or negedge reset_n) begin
      if (!reset_n) begin
         lr_q      <= 1'b0;
         cnt       <= 6'h0;
         acc       <= 24'h0;
         sr        <= 24'h0;
         word      <= 24'h0;
         word_left <= 1'b0;
         word_tgl  <= 1'b0;
      end else begin
         lr_q <= channel_select_clock;
         acc  <= next_acc;
         sr   <= next_sr;
         if (edge_seen) begin
            cnt       <= 6'h1;
            word      <= fmt_s2 == ASFE_FMT_RJ ? sr & mask : acc;
            word_left <= is_i2s ? !lr_q : lr_q;
            word_tgl  <= !word_tgl;
         end else if (cnt != `ASFE_CNT_MAX) begin
            cnt <= cnt + 6'h1;
         end
      end
   end
endmodule : asfe_rx

// File: hw/asfe_top.sv
`timescale 1ns/100ps
module asfe_top (
   input  wire logic           clk,
   input  wire logic           reset_n,
   input  wire logic           bit_clock,
   input  wire logic           channel_select_clock,
   input  wire logic           serial_data,
   input  wire logic           register_mode_pin,
   input  wire logic           amp_shutdown_n,
   input  wire logic           soft_clip_pin,
   input  wire logic           dc_detect,
   input  wire logic           i2c_scl,
   input  wire logic           i2c_sda_i,
   output logic                i2c_sda_o,
   output logic                i2c_sda_oe,
   output logic                amp_fault_n_o,
   output logic                amp_fault_n_oe,
   output logic                power_stage_en,
   output logic                soft_clip_en,
   output logic                double_speed,
   output asfe_pkg::asfe_smp_t audio_left,
   output asfe_pkg::asfe_smp_t audio_right,
   output logic                audio_valid
);
   import asfe_pkg::*;

   logic [7:0]   power_control, path_filter_control, serial_format;
   logic [7:0]   digital_volume_level, volume_ramp_config, applied_vol;
   logic [7:0]   target_vol, rd_data, i2c_ptr, i2c_sh;
   logic [1:0]   mode_s, sd_s, clip_s, dc_s, scl_s, sda_s;
   logic         scl_q, sda_q, reg_mode, sd_eff, dc_error_fault;
   logic [1:0]   fmt_eff, len_eff, boost_eff;
   logic         hpf_on;
   asfe_smp_t    rx_word, lw, rw, xl, xr, yl, yr, hl, hr;
   logic         rx_left, rx_tgl;
   logic [2:0]   tgl_s, fcnt;
   logic         new_word, frame_p, ramp_tick;
   asfe_i2c_st_e st;
   logic [3:0]   bcnt;
   logic         rd_op, nack, start_c, stop_c, scl_rise, scl_fall;
   logic         wr_en;
   logic [7:0]   wr_addr, wr_data;

   ////////////////////////////////////////////////////////////////////////
   // arithmetic helpers
   function automatic asfe_smp_t asfe_sat(input logic signed [47:0] v);
      if (v > 48'sh7fffff)
         return 24'sh7fffff;
      else if (v < -48'sh800000)
         return 24'sh800000;
      else
         return v[23:0];
   endfunction : asfe_sat

   function automatic asfe_smp_t asfe_hpf(input asfe_smp_t x,
                                           input asfe_smp_t xp,
                                           input asfe_smp_t yp);
      logic signed [47:0] v;
      v = 48'(x) - 48'(xp) + 48'(yp) - (48'(yp) >>> `ASFE_HPF_SHIFT);
      return asfe_sat(v);
   endfunction : asfe_hpf

   function automatic asfe_smp_t asfe_boost(input asfe_smp_t x,
                                             input logic [1:0] b);
      logic signed [47:0] v;
      v = 48'(x) <<< b;
      return asfe_sat(v);
   endfunction : asfe_boost

   // gain = 2^((code - 0xcf) / 12 ... in half dB steps)
   function automatic asfe_smp_t asfe_vol(input asfe_smp_t x,
                                           input logic [7:0] c);
      logic [8:0]         t;
      logic [4:0]         e;
      logic [3:0]         r;
      logic [15:0]        m;
      logic signed [47:0] p;
      t = {1'b0, c} + `ASFE_VOL_OFFS;
      e = 5'(t / `ASFE_VOL_DIV);
      r = 4'(t % `ASFE_VOL_DIV);
      case (r)
         4'd1:    m = 16'h879c;
         4'd2:    m = 16'h8fad;
         4'd3:    m = 16'h9838;
         4'd4:    m = 16'ha145;
         4'd5:    m = 16'haadc;
         4'd6:    m = 16'hb505;
         4'd7:    m = 16'hbfc9;
         4'd8:    m = 16'hcb30;
         4'd9:    m = 16'hd745;
         4'd10:   m = 16'he412;
         4'd11:   m = 16'hf1a2;
         default: m = 16'h8000;
      endcase
      p = 48'(x) * $signed({32'h0, m});
      p = (p <<< 4) >>> (`ASFE_VOL_SHIFT - 6'(e));
      if (c == `ASFE_VOL_MUTE)
         return 24'sh0;
      return asfe_sat(p);
   endfunction : asfe_vol

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         mode_s <= 2'h0;
         sd_s   <= 2'h0;
         clip_s <= 2'h0;
         dc_s   <= 2'h0;
         scl_s  <= 2'h3;
         sda_s  <= 2'h3;
         scl_q  <= 1'b1;
         sda_q  <= 1'b1;
      end else begin
         mode_s <= {mode_s[0], register_mode_pin};
         sd_s   <= {sd_s[0], amp_shutdown_n};
         clip_s <= {clip_s[0], soft_clip_pin};
         dc_s   <= {dc_s[0], dc_detect};
         scl_s  <= {scl_s[0], i2c_scl};
         sda_s  <= {sda_s[0], i2c_sda_i};
         scl_q  <= scl_s[1];
         sda_q  <= sda_s[1];
      end
   end

   always_comb begin
      reg_mode  = mode_s[1];
      sd_eff    = sd_s[1] && (!reg_mode
                  || power_control[`ASFE_BIT_SD]);
      fmt_eff   = reg_mode ? serial_format[`ASFE_FMT_LO +: 2]
                           : ASFE_FMT_I2S;
      len_eff   = reg_mode ? serial_format[`ASFE_LEN_LO +: 2]
                           : `ASFE_LEN_24;
      boost_eff = reg_mode ? path_filter_control[`ASFE_BOOST_LO +: 2]
                           : `ASFE_BOOST_HW;
      hpf_on    = !reg_mode
                  || !path_filter_control[`ASFE_BIT_HPF];
      target_vol = reg_mode ? digital_volume_level : `ASFE_VOL_UNITY;
      start_c   = scl_s[1] && scl_q && sda_q && !sda_s[1];
      stop_c    = scl_s[1] && scl_q && !sda_q && sda_s[1];
      scl_rise  = scl_s[1] && !scl_q;
      scl_fall  = !scl_s[1] && scl_q;
   end

   ////////////////////////////////////////////////////////////////////////
   // receiver on the link clock
   asfe_rx u_rx (
      .bit_clock            (bit_clock),
      .reset_n              (reset_n),
      .channel_select_clock (channel_select_clock),
      .serial_data          (serial_data),
      .fmt_cfg              (fmt_eff),
      .len_cfg              (len_eff),
      .word                 (rx_word),
      .word_left            (rx_left),
      .word_tgl             (rx_tgl)
   );

   // toggle crossing; word is held stable for a whole channel slot
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n)
         tgl_s <= 3'h0;
      else
         tgl_s <= {tgl_s[1:0], rx_tgl};
   end

   assign new_word = tgl_s[2] ^ tgl_s[1];

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         lw      <= 24'sh0;
         rw      <= 24'sh0;
         frame_p <= 1'b0;
      end else begin
         frame_p <= new_word && !rx_left;
         if (new_word && rx_left)
            lw <= rx_word;
         if (new_word && !rx_left)
            rw <= rx_word;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // audio path: DC blocker, boost, volume
   always_comb begin
      hl = hpf_on ? asfe_hpf(lw, xl, yl) : lw;
      hr = hpf_on ? asfe_hpf(rw, xr, yr) : rw;
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         xl          <= 24'sh0;
         xr          <= 24'sh0;
         yl          <= 24'sh0;
         yr          <= 24'sh0;
         audio_left  <= 24'sh0;
         audio_right <= 24'sh0;
         audio_valid <= 1'b0;
      end else begin
         audio_valid <= frame_p;
         if (frame_p) begin
            xl          <= lw;
            xr          <= rw;
            yl          <= hl;
            yr          <= hr;
            audio_left  <= asfe_vol(asfe_boost(hl, boost_eff),
                                    applied_vol);
            audio_right <= asfe_vol(asfe_boost(hr, boost_eff),
                                    applied_vol);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // volume ramp, one step per 8 frames
   assign ramp_tick = frame_p && fcnt == `ASFE_RAMP_LAST;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         fcnt        <= 3'h0;
         applied_vol <= `ASFE_VOL_UNITY;
      end else begin
         if (frame_p)
            fcnt <= fcnt + 3'h1;
         if (volume_ramp_config[`ASFE_BIT_RAMP])
            applied_vol <= target_vol;
         else if (ramp_tick && applied_vol < target_vol)
            applied_vol <= applied_vol + 8'h01;
         else if (ramp_tick && applied_vol > target_vol)
            applied_vol <= applied_vol - 8'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // fault, shutdown and pass-through pins
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n)
         dc_error_fault <= 1'b0;
      else if (dc_s[1] && sd_eff)
         dc_error_fault <= 1'b1;
      else if (!sd_eff)
         dc_error_fault <= 1'b0;
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         power_stage_en <= 1'b0;
         amp_fault_n_o  <= 1'b0;
         amp_fault_n_oe <= 1'b0;
         soft_clip_en   <= 1'b0;
         double_speed   <= 1'b0;
      end else begin
         power_stage_en <= sd_eff && !dc_error_fault
                           && !(dc_s[1] && sd_eff);
         amp_fault_n_o  <= 1'b0;
         amp_fault_n_oe <= dc_error_fault;
         soft_clip_en   <= clip_s[1];
         double_speed   <= reg_mode
                           && serial_format[`ASFE_BIT_SPEED];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // control registers
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         power_control        <= `ASFE_POWER_RST;
         path_filter_control  <= `ASFE_PATH_RST;
         serial_format        <= `ASFE_FORMAT_RST;
         digital_volume_level <= `ASFE_VOLUME_RST;
         volume_ramp_config   <= `ASFE_RAMP_RST;
      end else if (wr_en) begin
         case (wr_addr)
            `ASFE_REG_POWER:  power_control        <= wr_data;
            `ASFE_REG_PATH:   path_filter_control  <= wr_data;
            `ASFE_REG_FORMAT: serial_format        <= wr_data;
            `ASFE_REG_VOLUME: digital_volume_level <= wr_data;
            `ASFE_REG_RAMP:   volume_ramp_config   <= wr_data;
            default: ;
         endcase
      end
   end

   always_comb begin
      case (i2c_ptr)
         `ASFE_REG_POWER:  rd_data = power_control;
         `ASFE_REG_PATH:   rd_data = path_filter_control;
         `ASFE_REG_FORMAT: rd_data = serial_format;
         `ASFE_REG_VOLUME: rd_data = digital_volume_level;
         `ASFE_REG_RAMP:   rd_data = volume_ramp_config;
         `ASFE_REG_STATUS: rd_data = {5'h0, reg_mode,
                                      applied_vol != target_vol,
                                      dc_error_fault};
         `ASFE_REG_APPLY:  rd_data = applied_vol;
         default:          rd_data = 8'h00;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // two-wire control port slave
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         st         <= I2C_IDLE;
         bcnt       <= 4'h0;
         i2c_sh     <= 8'h00;
         i2c_ptr    <= 8'h00;
         rd_op      <= 1'b0;
         nack       <= 1'b0;
         i2c_sda_o  <= 1'b0;
         i2c_sda_oe <= 1'b0;
         wr_en      <= 1'b0;
         wr_addr    <= 8'h00;
         wr_data    <= 8'h00;
      end else begin
         wr_en     <= 1'b0;
         i2c_sda_o <= 1'b0;
         if (start_c) begin
            st         <= I2C_ADDR;
            bcnt       <= 4'h0;
            i2c_sda_oe <= 1'b0;
         end else if (stop_c) begin
            st         <= I2C_IDLE;
            i2c_sda_oe <= 1'b0;
         end else if (scl_rise) begin
            bcnt   <= bcnt + 4'h1;
            i2c_sh <= {i2c_sh[6:0], sda_s[1]};
            if (st == I2C_RACK)
               nack <= sda_s[1];
         end else if (scl_fall) begin
            case (st)
               I2C_ADDR: begin
                  if (bcnt == 4'h8) begin
                     if (i2c_sh[7:1] == `ASFE_I2C_ADDR) begin
                        st         <= I2C_ACK_A;
                        rd_op      <= i2c_sh[0];
                        i2c_sda_oe <= 1'b1;
                     end else begin
                        st <= I2C_IDLE;
                     end
                  end
               end
               I2C_ACK_A: begin
                  bcnt <= 4'h0;
                  if (rd_op) begin
                     st         <= I2C_RDATA;
                     i2c_sh     <= rd_data;
                     i2c_sda_oe <= !rd_data[7];
                  end else begin
                     st         <= I2C_PTR;
                     i2c_sda_oe <= 1'b0;
                  end
               end
               I2C_PTR: begin
                  if (bcnt == 4'h8) begin
                     i2c_ptr    <= i2c_sh;
                     st         <= I2C_ACK_W;
                     i2c_sda_oe <= 1'b1;
                  end
               end
               I2C_WDATA: begin
                  if (bcnt == 4'h8) begin
                     wr_en      <= 1'b1;
                     wr_addr    <= i2c_ptr;
                     i2c_ptr    <= i2c_ptr + 8'h01;
                     wr_data    <= i2c_sh;
                     st         <= I2C_ACK_W;
                     i2c_sda_oe <= 1'b1;
                  end
               end
               I2C_ACK_W: begin
                  // pointer moves on with each data byte, not here
                  bcnt       <= 4'h0;
                  st         <= I2C_WDATA;
                  i2c_sda_oe <= 1'b0;
               end
               I2C_RDATA: begin
                  if (bcnt == 4'h8) begin
                     st         <= I2C_RACK;
                     i2c_sda_oe <= 1'b0;
                     i2c_ptr    <= i2c_ptr + 8'h01;
                  end else begin
                     i2c_sda_oe <= !i2c_sh[7];
                  end
               end
               I2C_RACK: begin
                  bcnt <= 4'h0;
                  if (nack) begin
                     st <= I2C_IDLE;
                  end else begin
                     st         <= I2C_RDATA;
                     i2c_sh     <= rd_data;
                     i2c_sda_oe <= !rd_data[7];
                  end
               end
               default: ;
            endcase
         end
      end
   end
endmodule : asfe_top

// File: verif/asfe_chk_sva.sv
`timescale 1ns/100ps
module asfe_chk (
   input wire logic           clk,
   input wire logic           reset_n,
   input wire logic           amp_shutdown_n,
   input wire logic           soft_clip_pin,
   input wire logic           dc_detect,
   input wire logic           register_mode_pin,
   input wire logic           amp_fault_n_oe,
   input wire logic           power_stage_en,
   input wire logic           soft_clip_en,
   input wire logic           double_speed,
   input asfe_pkg::asfe_smp_t audio_left,
   input asfe_pkg::asfe_smp_t audio_right,
   input wire logic           audio_valid
);
   import asfe_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   AST_FAULT_SET: assert property (
      dc_detect && power_stage_en |-> ##[1:4] amp_fault_n_oe)
      else $error("dc fault not raised");
   AST_FAULT_LATCH: assert property (
      amp_shutdown_n[*4] ##0 amp_fault_n_oe |=> amp_fault_n_oe)
      else $error("dc fault dropped");
   AST_FAULT_STAGE: assert property (
      amp_fault_n_oe |-> !power_stage_en)
      else $error("stage on during fault");
   AST_SHUT_PIN: assert property (
      !amp_shutdown_n[*4] |-> !power_stage_en)
      else $error("stage on in shutdown");
   AST_CLIP_PIN: assert property (
      soft_clip_pin[*5] |-> soft_clip_en)
      else $error("soft clip pin ignored");
   AST_STRAP_SPEED: assert property (
      !register_mode_pin[*5] |-> !double_speed)
      else $error("double speed under straps");
   AST_VALID_PULSE: assert property (
      audio_valid |=> !audio_valid)
      else $error("valid longer than one cycle");
   AST_AUDIO_HOLD: assert property (
      !audio_valid |-> $stable({audio_left, audio_right}))
      else $error("audio moved without valid");
   cover property (audio_valid);
   cover property ($rose(amp_fault_n_oe));
   cover property (!amp_shutdown_n ##1 amp_shutdown_n);
endmodule : asfe_chk
bind asfe_top asfe_chk chk_u (.clk(clk), .reset_n(reset_n),
   .amp_shutdown_n(amp_shutdown_n), .soft_clip_pin(soft_clip_pin),
   .dc_detect(dc_detect), .register_mode_pin(register_mode_pin),
   .amp_fault_n_oe(amp_fault_n_oe), .power_stage_en(power_stage_en),
   .soft_clip_en(soft_clip_en), .double_speed(double_speed),
   .audio_left(audio_left), .audio_right(audio_right),
   .audio_valid(audio_valid));

// File: verif/asfe_src_model.sv
`timescale 1ns/100ps
module asfe_src_model (
   output logic bit_clock,
   output logic channel_select_clock,
   output logic serial_data
);
   initial begin
      bit_clock = 1'b0;
      channel_select_clock = 1'b0;
      serial_data = 1'b0;
   end
   task automatic put_bit(input logic c, input logic d);
      channel_select_clock = c;
      serial_data = d;
      #40 bit_clock = 1'b1;
      #40 bit_clock = 1'b0;
   endtask : put_bit
   // f: 0 i2s, 1 left-justified, 2 right-justified
   task automatic frame(input logic [1:0] f, input logic [23:0] l,
                        input logic [23:0] r, input logic setup);
      int k;
      int i;
      #3.3;
      // two lead-in bits let a new format cross on the bit clock
      if (setup) repeat (2) put_bit(f == 2'd0, ~serial_data);
      for (k = 0; k < 64; k++) begin
         i = (f == 2'd0) ? 24 - k % 32 :
             (f == 2'd1) ? 23 - k % 32 : 31 - k % 32;
         put_bit((k > 31) ^ (f != 2'd0),
                 (i >= 0 && i < 24) ? (k > 31 ? r[i] : l[i]) : ~serial_data);
      end
      serial_data = ~serial_data;
   endtask : frame
endmodule : asfe_src_model

// File: verif/tb_top.sv
`timescale 1ns/100ps
`include "asfe_cfg.svh"
module tb_top;
   import asfe_pkg::*;
   logic        clk, reset_n, mode, shut_n, clip, dc, scl, sda_m;
   wire         bclk, cs, sd, sda_o, sda_oe, flt_o, flt_oe, pwr, clip_en;
   wire         dspeed, valid;
   wire         sda = sda_m & ~sda_oe;
   asfe_smp_t   left, right;
   int          bad_count, checked, cyc, skip, seed;
   logic [47:0] q[$];
   asfe_top dut_u (.clk(clk), .reset_n(reset_n), .bit_clock(bclk),
      .channel_select_clock(cs), .serial_data(sd), .register_mode_pin(mode),
      .amp_shutdown_n(shut_n), .soft_clip_pin(clip), .dc_detect(dc),
      .i2c_scl(scl), .i2c_sda_i(sda), .i2c_sda_o(sda_o), .i2c_sda_oe(sda_oe),
      .amp_fault_n_o(flt_o), .amp_fault_n_oe(flt_oe), .power_stage_en(pwr),
      .soft_clip_en(clip_en), .double_speed(dspeed), .audio_left(left),
      .audio_right(right), .audio_valid(valid));
   asfe_src_model src_u (.bit_clock(bclk), .channel_select_clock(cs),
      .serial_data(sd));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic check(input logic [47:0] got, input logic [47:0] exp);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check
   task automatic complete_run;
      $display("checked=%0d bad_count=%0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : complete_run
   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask : tick
   task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
      logic [26:0] s;
      int i;
      s = {`ASFE_I2C_ADDR, 1'b0, 1'b1, a, 1'b1, d, 1'b1};
      sda_m = 1'b0;
      tick(5);
      for (i = 26; i >= 0; i--) begin
         scl = 1'b0;
         sda_m = s[i];
         tick(5);
         scl = 1'b1;
         tick(5);
         if (i % 9 == 0) check(48'(sda_oe), 48'h1);
      end
      scl = 1'b0;
      sda_m = 1'b0;
      tick(5);
      scl = 1'b1;
      tick(5);
      sda_m = 1'b1;
      tick(5);
   endtask : reg_wr
   function automatic logic [23:0] expw(input logic [1:0] f,
                                        input logic [23:0] w);
      if (f == 2'd1) return {w[23:8], 8'h00};
      if (f == 2'd2) return {8'h00, w[15:0]};
      return w;
   endfunction : expw
   task automatic run(input logic [1:0] f, input logic [7:0] r,
                      input logic m);
      logic [23:0] a, b;
      int n;
      reg_wr(`ASFE_REG_FORMAT, r);
      skip = 1;
      for (n = 0; n < 5; n++) begin
         a = n == 0 ? 24'h800001 : 24'($random(seed));
         b = 24'($random(seed));
         src_u.frame(f, a, b, n == 0);
         if (n == 0) skip = 0;
         if (n < 4) q.push_back(m ? 48'h0 : {expw(f, a), expw(f, b)});
      end
      tick(20);
      check(48'(q.size()), 48'h0);
   endtask : run
   always @(negedge clk) begin
      cyc++;
      if (cyc == 40000) begin
         bad_count++;
         complete_run;
      end else if (valid === 1'b1 && skip == 0) begin
         if (q.size() == 0) check({left, right}, ~{left, right});
         else check({left, right}, q.pop_front());
      end
   end
   initial begin
      seed = 11693;
      {reset_n, mode, clip, dc, sda_m, scl} = 6'h03;
      shut_n = 1'b1;
      tick(3);
      reset_n = 1'b1;
      tick(8);
      mode = 1'b1;
      clip = 1'b1;
      tick(4);
      reg_wr(`ASFE_REG_PATH, 8'h80);
      run(2'd0, 8'h0c, 1'b0);
      run(2'd1, 8'h01, 1'b0);
      run(2'd2, 8'h02, 1'b0);
      reg_wr(`ASFE_REG_RAMP, 8'h80);
      reg_wr(`ASFE_REG_VOLUME, 8'h00);
      run(2'd0, 8'h0c, 1'b1);
      dc = 1'b1;
      tick(10);
      dc = 1'b0;
      tick(10);
      check({clip_en, flt_oe, pwr}, 48'h6);
      shut_n = 1'b0;
      tick(10);
      check({flt_oe, pwr}, 48'h0);
      shut_n = 1'b1;
      tick(10);
      check({flt_oe, pwr}, 48'h1);
      check({sda_o, flt_o}, 48'h0);
      reg_wr(`ASFE_REG_FORMAT, 8'h1c);
      check(48'(dspeed), 48'h1);
      complete_run;
   end
endmodule : tb_top
